// [hw/trs_status_reset.sv]
// Master status and reset register with remote terminal soft resets
//
// Contract
// RULE1 - Writing 1 to remote 2 reset clears its start bit, then resets it.
// RULE2 - Writing 1 to remote 1 reset clears its start bit, then resets it.
// RULE3 - Reset bit reads high throughout reset, then clears itself.
// RULE4 - Any reset bit high holds ready low and suspends host access.
// RULE5 - With ready low, every read returns this register.
// RULE6 - On completion, ready rises and host access returns.
// RULE7 - Controller message flag high during message, falls after updates.
// RULE8 - Controller running flag high whenever the controller runs.
// RULE9 - Monitor message flag set on decoded command, cleared at end.
// RULE10 - Monitor packet flag set at packet start, cleared when complete.
// RULE11 - Register cleared by master reset, untouched by soft resets.
// RULE12 - Writing 0 does nothing; writes to flag bits are ignored.
// RULE13 - Host polls ready or reset bit before further access.
module trs_status_reset (
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic [15:0] host_addr,
    input  wire logic [15:0] host_wdata,
    input  wire logic        host_wr,
    input  wire logic        host_rd,
    input  wire logic [15:0] ext_rdata,
    input  wire logic [1:0]  remote_reset_done,
    input  wire logic        ctrl_msg_busy,
    input  wire logic        ctrl_enabled_running,
    input  wire logic        mon_cmd_decoded,
    input  wire logic        mon_msg_done,
    input  wire logic        mon_packet_start,
    input  wire logic        mon_packet_done,
    output logic [15:0]      host_rdata,
    output logic             host_rd_valid,
    output logic             ready,
    output logic [1:0]       remote_start_exec_clear,
    output logic [1:0]       remote_soft_reset_run
);
    import trs_pkg::*;

    logic [1:0]  remote_soft_reset_req;
    logic        controller_msg_in_progress;
    logic        controller_running;
    logic        monitor_msg_in_progress;
    logic        monitor_packet_in_progress;
    logic [15:0] status_word;
    logic        write_status;
    logic [1:0]  start_req;

    function automatic logic hits_status(input logic [15:0] addr);
        return addr == TRS_STATUS_OFFSET;
    endfunction

    // Writes are locked out while any soft reset runs
    assign write_status = host_wr && ready && hits_status(host_addr); // see RULE4

    // Only a 1 starts; a 0 is ignored
    assign start_req = {2{write_status}}
                     & host_wdata[TRS_REMOTE2_BIT:TRS_REMOTE1_BIT]; // see RULE12

    genvar g;
    generate
        for (g = 0; g < TRS_REMOTE_COUNT; g++) begin : g_remote
            trs_soft_reset_seq u_seq (
                .clk              (clk),
                .sys_rst          (sys_rst),
                .start            (start_req[g]),
                .engine_done      (remote_reset_done[g]),
                .busy             (remote_soft_reset_req[g]), // see RULE3
                .clear_start_exec (remote_start_exec_clear[g]), // see RULE1
                .run              (remote_soft_reset_run[g]) // see RULE2
            );
        end
    endgenerate

    always_comb begin
        status_word = TRS_STATUS_RESET;
        status_word[TRS_READY_BIT]    = ready;
        status_word[TRS_REMOTE2_BIT]  = remote_soft_reset_req[1];
        status_word[TRS_REMOTE1_BIT]  = remote_soft_reset_req[0];
        status_word[TRS_CTRL_MIP_BIT] = controller_msg_in_progress;
        status_word[TRS_CTRL_RUN_BIT] = controller_running;
        status_word[TRS_MON_MIP_BIT]  = monitor_msg_in_progress;
        status_word[TRS_MON_PIP_BIT]  = monitor_packet_in_progress;
    end

    // Ready comes back the cycle after the last reset bit drops
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ready <= 1'b0; // see RULE11
        end else begin
            // Falls on the edge a request rises, so no stale ready
            ready <= !(|remote_soft_reset_req)
                     && !(|start_req); // see RULE4 see RULE6
        end
    end

    // Engine levels; the engine drops busy only after its updates
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            controller_msg_in_progress <= 1'b0;
            controller_running         <= 1'b0;
        end else begin
            controller_msg_in_progress <= ctrl_msg_busy; // see RULE7
            controller_running         <= ctrl_enabled_running; // see RULE8
        end
    end

    // Set wins over a clear in the same cycle
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            monitor_msg_in_progress <= 1'b0;
        end else if (mon_cmd_decoded) begin
            monitor_msg_in_progress <= 1'b1; // see RULE9
        end else if (mon_msg_done) begin
            monitor_msg_in_progress <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            monitor_packet_in_progress <= 1'b0;
        end else if (mon_packet_start) begin
            monitor_packet_in_progress <= 1'b1; // see RULE10
        end else if (mon_packet_done) begin
            monitor_packet_in_progress <= 1'b0;
        end
    end

    // Read path; address is ignored while not ready
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            host_rdata    <= TRS_STATUS_RESET;
            host_rd_valid <= 1'b0;
        end else begin
            host_rd_valid <= host_rd;
            if (host_rd) begin
                if (!ready) begin
                    host_rdata <= status_word; // see RULE5
                end else if (hits_status(host_addr)) begin
                    host_rdata <= status_word;
                end else begin
                    host_rdata <= ext_rdata; // see RULE6
                end
            end
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);

    chk_remote2_clear_run: assert property ( // see RULE1
        write_status && host_wdata[TRS_REMOTE2_BIT] && !remote_soft_reset_req[1]
        |=> remote_start_exec_clear[1] && !remote_soft_reset_run[1]
        ##1 remote_soft_reset_run[1] && !remote_start_exec_clear[1])
        else $error("remote 2 reset did not clear start then run");

    chk_remote1_clear_run: assert property ( // see RULE2
        write_status && host_wdata[TRS_REMOTE1_BIT] && !remote_soft_reset_req[0]
        |=> remote_start_exec_clear[0] ##1 remote_soft_reset_run[0])
        else $error("remote 1 reset did not clear start then run");

    chk_req_self_clear: assert property ( // see RULE3
        remote_soft_reset_run[0] && remote_reset_done[0]
        |=> !remote_soft_reset_req[0] && !remote_soft_reset_run[0])
        else $error("remote 1 reset bit did not self clear");

    chk_busy_ready_low: assert property ( // see RULE4
        |remote_soft_reset_req |-> !ready)
        else $error("ready high during soft reset");

    chk_read_locked: assert property ( // see RULE5
        host_rd && !ready |=> host_rd_valid && host_rdata == $past(status_word))
        else $error("read while not ready did not return status");

    chk_ready_return: assert property ( // see RULE6
        $fell(|remote_soft_reset_req) |=> ready)
        else $error("ready not restored after soft reset");

    chk_ctrl_flags: assert property ( // see RULE7 see RULE8
        ##1 controller_msg_in_progress == $past(ctrl_msg_busy)
        && controller_running == $past(ctrl_enabled_running))
        else $error("controller flags do not follow engine");

    chk_mon_msg_set: assert property ( // see RULE9
        mon_cmd_decoded |=> monitor_msg_in_progress)
        else $error("monitor message flag not set");

    chk_mon_pkt_flag: assert property ( // see RULE10
        mon_packet_done && !mon_packet_start |=> !monitor_packet_in_progress)
        else $error("monitor packet flag not cleared");

    chk_master_clear: assert property ( // see RULE11
        disable iff (1'b0) sys_rst |=> status_word == TRS_STATUS_RESET)
        else $error("register not cleared by master reset");

    chk_zero_write: assert property ( // see RULE12
        write_status && !host_wdata[TRS_REMOTE1_BIT] && !remote_soft_reset_req[0]
        |=> !remote_soft_reset_req[0])
        else $error("writing 0 started a soft reset");

    chk_write_locked: assert property ( // see RULE4
        host_wr && !ready |=> remote_start_exec_clear == 2'b00)
        else $error("write accepted while not ready");

    chk_clear_pulse: assert property ( // see RULE1 see RULE2
        |remote_start_exec_clear |=> remote_start_exec_clear == 2'b00)
        else $error("start clear pulse longer than one cycle");

    chk_req_covers_run: assert property ( // see RULE3
        (remote_soft_reset_run & ~remote_soft_reset_req) == 2'b00)
        else $error("reset bit low while reset actions run");

    chk_remote2_self_clear: assert property ( // see RULE3
        remote_soft_reset_run[1] && remote_reset_done[1]
        |=> !remote_soft_reset_req[1] && !remote_soft_reset_run[1])
        else $error("remote 2 reset bit did not self clear");

    chk_status_read: assert property ( // see RULE5
        host_rd && hits_status(host_addr)
        |=> host_rd_valid && host_rdata == $past(status_word))
        else $error("status read returned wrong word");

    chk_read_open: assert property ( // see RULE6
        host_rd && ready && !hits_status(host_addr)
        |=> host_rd_valid && host_rdata == $past(ext_rdata))
        else $error("open read did not return outside data");

    chk_mon_msg_clear: assert property ( // see RULE9
        mon_msg_done && !mon_cmd_decoded |=> !monitor_msg_in_progress)
        else $error("monitor message flag not cleared");

    chk_mon_pkt_set: assert property ( // see RULE10
        mon_packet_start |=> monitor_packet_in_progress)
        else $error("monitor packet flag not set");
endmodule // trs_status_reset

// [hw/trs_pkg.sv]
// Package: offsets, bit positions and reset values of the status register
package trs_pkg;
    localparam logic [15:0] TRS_STATUS_OFFSET  = 16'h0001;
    localparam logic [15:0] TRS_STATUS_RESET   = 16'h0000;
    localparam int          TRS_READY_BIT      = 15;
    localparam int          TRS_REMOTE2_BIT    = 11;
    localparam int          TRS_REMOTE1_BIT    = 10;
    localparam int          TRS_CTRL_MIP_BIT   = 9;
    localparam int          TRS_CTRL_RUN_BIT   = 8;
    localparam int          TRS_MON_MIP_BIT    = 7;
    localparam int          TRS_MON_PIP_BIT    = 6;
    localparam int          TRS_REMOTE_COUNT   = 2;

    typedef enum logic [1:0] {
        TRS_SEQ_IDLE  = 2'b00,
        TRS_SEQ_CLEAR = 2'b01,
        TRS_SEQ_RUN   = 2'b10
    } trs_seq_state_type;
endpackage

// [hw/trs_soft_reset_seq.sv]
// Soft reset sequencer for one remote terminal
module trs_soft_reset_seq (
    input  wire logic clk,
    input  wire logic sys_rst,
    input  wire logic start,
    input  wire logic engine_done,
    output logic      busy,
    output logic      clear_start_exec,
    output logic      run
);
    import trs_pkg::*;

    trs_seq_state_type state;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state <= TRS_SEQ_IDLE;
        end else begin
            case (state)
                TRS_SEQ_IDLE: begin
                    if (start) begin
                        state <= TRS_SEQ_CLEAR;
                    end
                end
                TRS_SEQ_CLEAR: begin
                    state <= TRS_SEQ_RUN;
                end
                TRS_SEQ_RUN: begin
                    if (engine_done) begin
                        state <= TRS_SEQ_IDLE;
                    end
                end
                default: begin
                    state <= TRS_SEQ_IDLE;
                end
            endcase
        end
    end

    // Request bit stays high from the write to completion
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            busy             <= 1'b0;
            clear_start_exec <= 1'b0;
            run              <= 1'b0;
        end else begin
            busy             <= (state == TRS_SEQ_IDLE) ? start
                              : !((state == TRS_SEQ_RUN) && engine_done);
            clear_start_exec <= (state == TRS_SEQ_IDLE) && start;
            run              <= (state == TRS_SEQ_CLEAR)
                              || ((state == TRS_SEQ_RUN) && !engine_done);
        end
    end
endmodule // trs_soft_reset_seq

// [verification/trs_remote_model.sv]
// Remote terminal engines answering soft reset requests
module trs_remote_model #(
    parameter int DLY0 = 6,
    parameter int DLY1 = 10
) (
    input  wire logic       clk,
    input  wire logic [1:0] run,
    output logic      [1:0] done
);
    int cnt [2];

    always_ff @(posedge clk) begin
        for (int i = 0; i < 2; i++) begin
            cnt[i] <= run[i] ? cnt[i] + 1 : 0;
        end
    end

    // Slow second engine keeps the lockout window long
    assign done[0] = run[0] && cnt[0] >= DLY0;
    assign done[1] = run[1] && cnt[1] >= DLY1;
endmodule // trs_remote_model

// [verification/trs_status_reset_tb_top.sv]
// Bench for the status and reset register
module trs_status_reset_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import trs_pkg::*;

    logic        clk = 0, sys_rst = 1, host_wr = 0, host_rd = 0;
    logic [15:0] host_addr = '0, host_wdata = '0, ext_rdata = '0;
    logic        ctrl_msg_busy = 0, ctrl_enabled_running = 0;
    logic        mon_cmd_decoded = 0, mon_msg_done = 0;
    logic        mon_packet_start = 0, mon_packet_done = 0;
    logic [15:0] host_rdata, v;
    logic        host_rd_valid, ready;
    logic [1:0]  done, clr, run;
    logic [3:0]  r;
    int          miscompares = 0, comparisons = 0;

    trs_status_reset uut (
        .clk(clk), .sys_rst(sys_rst), .host_addr(host_addr),
        .host_wdata(host_wdata), .host_wr(host_wr), .host_rd(host_rd),
        .ext_rdata(ext_rdata), .remote_reset_done(done),
        .ctrl_msg_busy(ctrl_msg_busy),
        .ctrl_enabled_running(ctrl_enabled_running),
        .mon_cmd_decoded(mon_cmd_decoded), .mon_msg_done(mon_msg_done),
        .mon_packet_start(mon_packet_start),
        .mon_packet_done(mon_packet_done), .host_rdata(host_rdata),
        .host_rd_valid(host_rd_valid), .ready(ready),
        .remote_start_exec_clear(clr), .remote_soft_reset_run(run)
    );

    trs_remote_model #(.DLY0(6), .DLY1(10)) partner (
        .clk(clk), .run(run), .done(done)
    );

    initial begin
        forever #25 clk = ~clk;
    end

    task check(input string n, input logic [15:0] seen, exp);
        comparisons++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", n, exp, seen);
        end
    endtask

    task results;
        $display("comparisons %0d miscompares %0d", comparisons,
                 miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task wr(input logic [15:0] a, d);
        @(negedge clk);
        host_wr = 1;
        host_addr = a;
        host_wdata = d;
        @(negedge clk);
        host_wr = 0;
    endtask

    // Missing valid pulse turns the value unknown
    task rd(input logic [15:0] a, output logic [15:0] q);
        @(negedge clk);
        host_rd = 1;
        host_addr = a;
        ext_rdata = 16'($urandom);
        @(negedge clk);
        host_rd = 0;
        q = host_rd_valid === 1'b1 ? host_rdata : 'x;
    endtask

    task wait_ready;
        for (int i = 0; i < 60 && ready !== 1'b1; i++) @(negedge clk);
        if (ready !== 1'b1) begin
            miscompares++;
            results;
        end
    endtask

    function automatic logic [15:0] flags(logic [3:0] f);
        return {1'b1, 5'h00, f[0], f[1], f[2], f[3], 6'h00};
    endfunction

    initial begin
        repeat (5000) @(posedge clk);
        miscompares++;
        results;
    end

    initial begin
        void'($urandom(32'hC3475AC1));
        repeat (2) @(negedge clk);
        sys_rst = 0;
        rd(16'h0001, v);
        check("status", v, 16'h8000);
        rd(16'h0005, v);
        check("ext", v, ext_rdata);
        wr(16'h0001, 16'h83C0);
        wr(16'h0002, 16'h0C00);
        rd(16'h0001, v);
        check("ignored", v, 16'h8000);
        for (int t = 0; t < 2; t++) begin
            wr(16'h0001, 16'h0400 << t);
            check("clear", 16'(clr), 16'(1 << t));
            check("ready_now", 16'(ready), 16'h0000);
            @(negedge clk);
            check("run", 16'(run), 16'(1 << t));
            check("ready", 16'(ready), 16'h0000);
            wr(16'h0001, 16'h0400 << (1 - t));
            rd(16'($urandom), v);
            check("locked", v, 16'h0400 << t);
            wait_ready;
            rd(16'h0001, v);
            check("done", v, 16'h8000);
        end
        // Second write right behind the first must be locked out
        @(negedge clk);
        {host_wr, host_addr, host_wdata} = {1'b1, 16'h0001, 16'h0400};
        @(negedge clk);
        host_wdata = 16'h0800;
        @(negedge clk);
        host_wr = 0;
        rd(16'h0001, v);
        check("b2b", v, 16'h0400);
        wait_ready;
        for (int i = 0; i < 6; i++) begin
            r = (i % 5 == 0) ? 4'hF : 4'($urandom);
            @(negedge clk);
            {mon_msg_done, mon_packet_done} = 2'h3;
            @(negedge clk);
            {mon_msg_done, mon_packet_done} = 2'h0;
            {mon_packet_start, mon_cmd_decoded} = r[3:2];
            {ctrl_enabled_running, ctrl_msg_busy} = r[1:0];
            @(negedge clk);
            {mon_packet_start, mon_cmd_decoded} = 2'h0;
            rd(16'h0001, v);
            check("flags", v, flags(r));
        end
        {ctrl_enabled_running, ctrl_msg_busy} = 2'h0;
        sys_rst = 1;
        repeat (2) @(negedge clk);
        sys_rst = 0;
        rd(16'h0001, v);
        check("master", v, 16'h8000);
        results;
    end
endmodule // trs_status_reset_tb_top
